// ---- verilog/ccs_interp.sv ----
/*
 Common command interpreter: takes decoded command beats, runs
 completion sync, status, user data, setup and reset commands and
 returns replies as ASCII bytes. Assumes a parser ahead of it that
 decodes headers and arguments, and a device on the same clock.
*/
`include "ccs_defs.svh"
// Contract
// - Query replies 1 after pending operations
// - Completion command sets event bit 0
// - Wait command stalls later commands
// - Clear status clears event and state change registers, keeps enables, cancels completion
// - Event query replies decimal, then clears
// - Event enable set and queried
// - Service enable set and queried
// - Status byte query returns status byte
// - User data written unless secure; oversize writes first 64 bytes, commits no length
// - User data query returns stored bytes
// - Reset restores power-up state, stops triggering
// - Trigger command equals device trigger
// - Save copies setup into slot
// - Recall restores setup from slot
// - Self-test requests device test, reports result
// - Identity query gives model, serial, firmware
// - Learn query returns restorable state
// - Options query reports hardware, software
// - Device can raise service request
module ccs_interp import ccs_pkg::*; #(
	parameter ccs_byte_t MODEL_ID  = 8'h2a, // Arbitrary value
	parameter ccs_byte_t SERIAL_ID = 8'h07, // Arbitrary value
	parameter ccs_byte_t FW_REV    = 8'h11, // Arbitrary value
	parameter ccs_byte_t SETUP_DEF = 8'h00
)(
	// Clock and reset
	input  wire logic        clock,
	input  wire logic        reset_n,
	// Command beats
	input  wire logic        cmd_valid,
	output logic             cmd_ready,
	input  wire logic [4:0]  cmd_code,
	input  wire logic [7:0]  cmd_arg,
	input  wire logic        cmd_last,
	// Reply bytes
	output logic             reply_valid,
	output logic [7:0]       reply_byte,
	output logic             reply_last,
	input  wire logic        reply_ready,
	// Device status in
	input  wire logic        ops_busy,
	input  wire logic        nv_secure,
	input  wire logic        tst_done,
	input  wire logic        tst_fail,
	input  wire logic        err_avail,
	input  wire logic [7:0]  evt_events,
	input  wire logic [15:0] isc_events,
	input  wire logic [7:0]  hw_opts,
	input  wire logic [7:0]  sw_opts,
	input  wire logic [7:0]  setup_live,
	// Device control out
	output logic             tst_req,
	output logic             dev_trigger,
	output logic             trigger_stop,
	output logic             dev_reset,
	output logic             err_clear,
	output logic             setup_load,
	output logic [7:0]       setup_value,
	output logic [15:0]      state_change,
	output logic             srq
);
	ccs_if b ();

	ccs_state_e state, next_state;
	ccs_byte_t  fld [0:2], next_fld [0:2];
	logic [1:0] fn, next_fn, fi, next_fi, dp, next_dp;
	logic       sep, next_sep, raw, next_raw, pend, next_pend;
	logic       opc_armed, next_opc_armed, acc;
	logic [6:0] cnt, next_cnt, idx;
	logic [5:0] ri, next_ri;
	ccs_byte_t  next_reply_byte, next_setup_value;
	logic       next_reply_valid, next_reply_last, next_tst_req, next_dev_trigger;
	logic       next_trigger_stop, next_dev_reset, next_err_clear, next_setup_load;

	// ----------------------------------------
	// Decimal helpers
	// ----------------------------------------
	function automatic logic [1:0] top_pos(input ccs_byte_t v);
		return (v >= 8'h64) ? 2'h2 : ((v >= 8'h0a) ? 2'h1 : 2'h0);
	endfunction

	function automatic ccs_byte_t dec_char(input ccs_byte_t v, input logic [1:0] p);
		ccs_byte_t d;
		d = v % 8'h0a;
		if (p == 2'h1)
			d = (v / 8'h0a) % 8'h0a;
		else if (p == 2'h2)
			d = v / 8'h64;
		return `CCS_CH_ZERO + d;
	endfunction

	// ----------------------------------------
	// Command acceptance
	// ----------------------------------------
	// stall while waiting or replying
	assign cmd_ready = (state == ST_IDLE && !reply_valid) || state == ST_PUD;
	assign acc = cmd_valid && cmd_ready;
	assign idx = (state == ST_PUD) ? cnt : 7'h00;

	// Next state, fields, strobes and reply byte
	always_comb
	begin
		next_state = state;
		next_fld = fld;
		next_fn = fn;
		next_fi = fi;
		next_dp = dp;
		next_sep = sep;
		next_raw = raw;
		next_pend = pend;
		next_cnt = cnt;
		next_ri = ri;
		next_opc_armed = opc_armed;
		next_setup_value = setup_value;
		next_reply_valid = reply_valid && !reply_ready;
		next_reply_byte = reply_byte;
		next_reply_last = reply_last;
		next_tst_req = 1'b0;
		next_dev_trigger = 1'b0;
		next_trigger_stop = 1'b0;
		next_dev_reset = 1'b0;
		next_err_clear = 1'b0;
		next_setup_load = 1'b0;
		b.cls = 1'b0;
		b.rst = 1'b0;
		b.evt_en_wr = 1'b0;
		b.srq_en_wr = 1'b0;
		b.evt_rd = 1'b0;
		b.opc_set = 1'b0;
		b.exe_err = 1'b0;
		b.cme_err = 1'b0;
		b.pud_wr = 1'b0;
		b.pud_commit = 1'b0;
		b.sav = 1'b0;
		b.wdata = cmd_arg;
		b.pud_addr = idx[5:0];
		b.pud_len_new = 7'(idx + 7'h01);
		b.pud_raddr = ri;
		b.slot = cmd_arg[1:0];
		b.setup_in = setup_live;
		b.mav = reply_valid || state == ST_REPLY;
		if (opc_armed && !ops_busy)
		begin
			b.opc_set = 1'b1;
			next_opc_armed = 1'b0;
		end
		unique case (state)
			ST_IDLE:
				if (acc)
				begin
					next_fn = 2'h1;
					unique case (cmd_code)
						CMD_CLS:
						begin
							b.cls = 1'b1;
							next_err_clear = 1'b1;
							next_opc_armed = 1'b0;
						end
						CMD_EVT_EN: b.evt_en_wr = 1'b1;
						CMD_SRQ_EN: b.srq_en_wr = 1'b1;
						CMD_EVT_EN_Q:
						begin
							next_fld[0] = b.evt_en;
							next_state = ST_REPLY;
						end
						CMD_SRQ_EN_Q:
						begin
							next_fld[0] = b.srq_en;
							next_state = ST_REPLY;
						end
						CMD_STB_Q:
						begin
							next_fld[0] = b.status_byte;
							next_state = ST_REPLY;
						end
						CMD_EVT_Q:
						begin
							next_fld[0] = b.evt;
							b.evt_rd = 1'b1;
							next_state = ST_REPLY;
						end
						CMD_IDN_Q:
						begin
							next_fld = '{MODEL_ID, SERIAL_ID, FW_REV};
							next_fn = 2'h3;
							next_state = ST_REPLY;
						end
						CMD_LRN_Q:
						begin
							next_fld = '{b.evt_en, b.srq_en, setup_live};
							next_fn = 2'h3;
							next_state = ST_REPLY;
						end
						CMD_OPT_Q:
						begin
							next_fld = '{hw_opts, sw_opts, `CCS_RST_BYTE};
							next_fn = 2'h2;
							next_state = ST_REPLY;
						end
						CMD_OPC: next_opc_armed = 1'b1;
						CMD_OPC_Q, CMD_WAI:
						begin
							next_pend = (cmd_code == CMD_OPC_Q);
							next_state = ST_WAIT;
						end
						CMD_PUD:
						begin
						end
						CMD_PUD_Q:
							if (b.pud_len != `CCS_RST_LEN)
							begin
								next_raw = 1'b1;
								next_state = ST_REPLY;
							end
						CMD_RCL:
						begin
							next_setup_value = b.setup_out;
							next_setup_load = 1'b1;
						end
						CMD_RST:
						begin
							b.rst = 1'b1;
							next_dev_reset = 1'b1;
							next_trigger_stop = 1'b1;
							next_setup_value = SETUP_DEF;
							next_setup_load = 1'b1;
							next_opc_armed = 1'b0;
						end
						CMD_SAV: b.sav = 1'b1;
						CMD_TRG: next_dev_trigger = 1'b1;
						CMD_TST_Q:
						begin
							next_tst_req = 1'b1;
							next_state = ST_TEST;
						end
						default: b.cme_err = 1'b1;
					endcase
				end
			ST_WAIT:
				if (!ops_busy)
				begin
					next_fld[0] = 8'h01;
					next_state = pend ? ST_REPLY : ST_IDLE;
				end
			ST_TEST:
				if (tst_done)
				begin
					next_fld[0] = {7'h00, tst_fail};
					next_state = ST_REPLY;
				end
			ST_PUD:
			begin
			end
			ST_REPLY:
				if (!reply_valid || reply_ready)
				begin
					next_reply_valid = 1'b1;
					next_reply_last = 1'b0;
					if (raw)
					begin
						next_reply_byte = b.pud_rdata;
						next_ri = 6'(ri + 6'h01);
						if ({1'b0, ri} == 7'(b.pud_len - 7'h01))
						begin
							next_reply_last = 1'b1;
							next_raw = 1'b0;
							next_state = ST_IDLE;
						end
					end
					else if (sep)
					begin
						next_reply_byte = `CCS_CH_COMMA;
						next_sep = 1'b0;
						next_fi = 2'(fi + 2'h1);
						next_dp = top_pos(fld[2'(fi + 2'h1)]);
					end
					else
					begin
						next_reply_byte = dec_char(fld[fi], dp);
						if (dp != 2'h0)
							next_dp = 2'(dp - 2'h1);
						else if (fi == 2'(fn - 2'h1))
						begin
							next_reply_last = 1'b1;
							next_state = ST_IDLE;
						end
						else
							next_sep = 1'b1;
					end
				end
		endcase
		if (acc && (state == ST_PUD || cmd_code == CMD_PUD))
		begin
			b.pud_wr = !nv_secure && idx < `CCS_PUD_MAX;
			next_cnt = (idx == `CCS_CNT_TOP) ? idx : 7'(idx + 7'h01);
			next_state = cmd_last ? ST_IDLE : ST_PUD;
			if (cmd_last && (nv_secure || idx >= `CCS_PUD_MAX))
				b.exe_err = 1'b1;
			else if (cmd_last)
				b.pud_commit = 1'b1;
		end
		// Start of a reply
		if (next_state == ST_REPLY && state != ST_REPLY)
		begin
			next_fi = 2'h0;
			next_sep = 1'b0;
			next_ri = 6'h00;
			next_dp = top_pos(next_fld[0]);
		end
	end

	// Registers
	always_ff @(posedge clock)
	begin
		if (!reset_n)
		begin
			state <= ST_IDLE;
			fld <= '{default: `CCS_RST_BYTE};
			fn <= 2'h1;
			fi <= 2'h0;
			dp <= 2'h0;
			sep <= 1'b0;
			raw <= 1'b0;
			pend <= 1'b0;
			cnt <= 7'h00;
			ri <= 6'h00;
			opc_armed <= 1'b0;
			setup_value <= SETUP_DEF;
			reply_valid <= 1'b0;
			reply_byte <= `CCS_RST_BYTE;
			reply_last <= 1'b0;
			tst_req <= 1'b0;
			dev_trigger <= 1'b0;
			trigger_stop <= 1'b0;
			dev_reset <= 1'b0;
			err_clear <= 1'b0;
			setup_load <= 1'b0;
		end
		else
		begin
			state <= next_state;
			fld <= next_fld;
			fn <= next_fn;
			fi <= next_fi;
			dp <= next_dp;
			sep <= next_sep;
			raw <= next_raw;
			pend <= next_pend;
			cnt <= next_cnt;
			ri <= next_ri;
			opc_armed <= next_opc_armed;
			setup_value <= next_setup_value;
			reply_valid <= next_reply_valid;
			reply_byte <= next_reply_byte;
			reply_last <= next_reply_last;
			tst_req <= next_tst_req;
			dev_trigger <= next_dev_trigger;
			trigger_stop <= next_trigger_stop;
			dev_reset <= next_dev_reset;
			err_clear <= next_err_clear;
			setup_load <= next_setup_load;
		end
	end

	// ----------------------------------------
	// Status registers and store
	// ----------------------------------------
	ccs_status u_status (
		.clock        (clock),
		.reset_n      (reset_n),
		.b            (b.stat),
		.evt_events   (evt_events),
		.isc_events   (isc_events),
		.err_avail    (err_avail),
		.state_change (state_change),
		.srq          (srq)
	);

	ccs_nvstore #(.SETUP_DEF(SETUP_DEF)) u_store (
		.clock   (clock),
		.reset_n (reset_n),
		.b       (b.store)
	);

	// ----------------------------------------
	// Checks
	// ----------------------------------------
	default clocking cb @(posedge clock); endclocking
	default disable iff (!reset_n);

	sequence s_opc_query;
		acc && state == ST_IDLE && cmd_code == CMD_OPC_Q;
	endsequence

	a_opc_reply: assert property (
		s_opc_query ##1 !ops_busy |-> ##2 (reply_valid && reply_byte == 8'h31 && reply_last))
		else $error("completion reply missing");
	a_opc_hold: assert property (
		s_opc_query ##1 ops_busy |-> ##2 !reply_valid) else $error("completion reply too early");
	a_opc_flag: assert property (
		(opc_armed && !ops_busy) |=> b.evt[`CCS_EVT_OPC]) else $error("completion bit not set");
	a_wai_hold: assert property (
		(state == ST_WAIT && ops_busy) |-> !cmd_ready ##1 (state == ST_WAIT))
		else $error("command taken while waiting");
	a_cls_cancel: assert property (
		(acc && state == ST_IDLE && cmd_code == CMD_CLS) |=> !opc_armed)
		else $error("completion not cancelled");
	a_pud_guard: assert property (
		b.pud_wr |-> (!nv_secure && idx < 7'h40)) else $error("guarded user data written");
	a_rst_state: assert property (
		(acc && state == ST_IDLE && cmd_code == CMD_RST)
		|=> (dev_reset && trigger_stop && setup_value == SETUP_DEF && !opc_armed))
		else $error("reset incomplete");
	a_trg_pulse: assert property (
		(acc && state == ST_IDLE && cmd_code == CMD_TRG) |=> dev_trigger ##1 !dev_trigger)
		else $error("trigger pulse wrong");
endmodule

// ---- verilog/ccs_defs.svh ----
/*
 Bit positions, sizes, reset values and character codes of the
 common command block. Assumes inclusion by bare name.
*/
`ifndef CCS_DEFS_SVH
`define CCS_DEFS_SVH
// ----------------------------------------
// Status bit positions
// ----------------------------------------
`define CCS_EVT_OPC  0
`define CCS_EVT_EXE  4
`define CCS_EVT_CME  5
`define CCS_STB_ISC  0
`define CCS_STB_EAV  2
`define CCS_STB_MAV  4
`define CCS_STB_ESB  5
`define CCS_STB_MSS  6
`define CCS_MSS_MASK 8'hbf
// ----------------------------------------
// Sizes and reset values
// ----------------------------------------
`define CCS_PUD_MAX  7'h40
`define CCS_CNT_TOP  7'h7f
`define CCS_RST_BYTE 8'h00
`define CCS_RST_WORD 16'h0000
`define CCS_RST_LEN  7'h00
// ----------------------------------------
// Reply characters
// ----------------------------------------
`define CCS_CH_ZERO  8'h30
`define CCS_CH_COMMA 8'h2c
`endif

// ---- verilog/ccs_pkg.sv ----
/*
 Types of the common command block: command codes, states, bytes.
 Assumes nothing of its surroundings.
*/
package ccs_pkg;
	// Command codes on cmd_code
	typedef enum logic [4:0] {
		CMD_CLS      = 5'h00, CMD_EVT_EN  = 5'h01, CMD_EVT_EN_Q = 5'h02,
		CMD_EVT_Q    = 5'h03, CMD_IDN_Q   = 5'h04, CMD_LRN_Q    = 5'h05,
		CMD_OPC      = 5'h06, CMD_OPC_Q   = 5'h07, CMD_OPT_Q    = 5'h08,
		CMD_PUD      = 5'h09, CMD_PUD_Q   = 5'h0a, CMD_RCL      = 5'h0b,
		CMD_RST      = 5'h0c, CMD_SAV     = 5'h0d, CMD_SRQ_EN   = 5'h0e,
		CMD_SRQ_EN_Q = 5'h0f, CMD_STB_Q   = 5'h10, CMD_TRG      = 5'h11,
		CMD_TST_Q    = 5'h12, CMD_WAI     = 5'h13
	} ccs_cmd_e;
	// Interpreter states
	typedef enum logic [4:0] {
		ST_IDLE  = 5'b00001,
		ST_WAIT  = 5'b00010,
		ST_TEST  = 5'b00100,
		ST_PUD   = 5'b01000,
		ST_REPLY = 5'b10000
	} ccs_state_e;
	typedef logic [7:0] ccs_byte_t;
endpackage

// ---- verilog/ccs_if.sv ----
/*
 Strobes and status between the interpreter, the status registers
 and the store. Assumes one clock for all three.
*/
interface ccs_if import ccs_pkg::*;;
	logic      cls, rst, evt_en_wr, srq_en_wr, evt_rd, opc_set;
	logic      exe_err, cme_err, mav, pud_wr, pud_commit, sav;
	ccs_byte_t wdata, evt, evt_en, srq_en, status_byte;
	logic [5:0] pud_addr, pud_raddr;
	logic [6:0] pud_len_new, pud_len;
	ccs_byte_t pud_rdata, setup_in, setup_out;
	logic [1:0] slot;
	modport ctl (output cls, rst, evt_en_wr, srq_en_wr, evt_rd, opc_set, exe_err,
		cme_err, mav, pud_wr, pud_commit, sav, wdata, pud_addr, pud_raddr,
		pud_len_new, setup_in, slot,
		input evt, evt_en, srq_en, status_byte, pud_len, pud_rdata, setup_out);
	modport stat (input cls, rst, evt_en_wr, srq_en_wr, evt_rd, opc_set, exe_err,
		cme_err, mav, wdata, output evt, evt_en, srq_en, status_byte);
	modport store (input pud_wr, pud_commit, sav, wdata, pud_addr, pud_raddr,
		pud_len_new, setup_in, slot, output pud_len, pud_rdata, setup_out);
endinterface

// ---- verilog/ccs_status.sv ----
/*
 Event status, enables, state change register, status byte and
 service request. Assumes strobes from the interpreter on one clock.
*/
`include "ccs_defs.svh"
module ccs_status import ccs_pkg::*; (
	// Clock and reset
	input  wire logic        clock,
	input  wire logic        reset_n,
	// Interpreter side
	ccs_if.stat              b,
	// Device events
	input  wire logic [7:0]  evt_events,
	input  wire logic [15:0] isc_events,
	input  wire logic        err_avail,
	// Status out
	output logic [15:0]      state_change,
	output logic             srq
);
	ccs_byte_t   evt, evt_en, srq_en, next_evt, next_evt_en, next_srq_en, set, stb;
	logic [15:0] next_state_change;
	logic        next_srq;

	// ----------------------------------------
	// Next values
	// ----------------------------------------
	always_comb
	begin
		set = evt_events;
		set[`CCS_EVT_OPC] = evt_events[`CCS_EVT_OPC] | b.opc_set;
		set[`CCS_EVT_EXE] = evt_events[`CCS_EVT_EXE] | b.exe_err;
		set[`CCS_EVT_CME] = evt_events[`CCS_EVT_CME] | b.cme_err;
		next_evt = ((b.cls || b.rst || b.evt_rd) ? `CCS_RST_BYTE : evt) | set;
		next_evt_en = b.rst ? `CCS_RST_BYTE : (b.evt_en_wr ? b.wdata : evt_en);
		next_srq_en = b.rst ? `CCS_RST_BYTE : (b.srq_en_wr ? b.wdata : srq_en);
		next_state_change = ((b.cls || b.rst) ? `CCS_RST_WORD : state_change) | isc_events;
		stb = `CCS_RST_BYTE;
		stb[`CCS_STB_ISC] = |state_change;
		stb[`CCS_STB_EAV] = err_avail;
		stb[`CCS_STB_MAV] = b.mav;
		stb[`CCS_STB_ESB] = |(evt & evt_en);
		stb[`CCS_STB_MSS] = |(stb & srq_en & `CCS_MSS_MASK);
		next_srq = stb[`CCS_STB_MSS];
	end

	// Registers
	always_ff @(posedge clock)
	begin
		if (!reset_n)
		begin
			evt          <= `CCS_RST_BYTE;
			evt_en       <= `CCS_RST_BYTE;
			srq_en       <= `CCS_RST_BYTE;
			state_change <= `CCS_RST_WORD;
			srq          <= 1'b0;
		end
		else
		begin
			evt          <= next_evt;
			evt_en       <= next_evt_en;
			srq_en       <= next_srq_en;
			state_change <= next_state_change;
			srq          <= next_srq;
		end
	end

	assign b.evt         = evt;
	assign b.evt_en      = evt_en;
	assign b.srq_en      = srq_en;
	assign b.status_byte = stb;

	// ----------------------------------------
	// Checks
	// ----------------------------------------
	default clocking cb @(posedge clock); endclocking
	default disable iff (!reset_n);

	a_evt_read_clear: assert property (
		(b.evt_rd && evt_events == 8'h00 && !b.opc_set && !b.exe_err && !b.cme_err)
		|=> evt == 8'h00) else $error("event status not cleared by read");
	a_evt_en_load: assert property (
		(b.evt_en_wr && !b.rst) |=> evt_en == $past(b.wdata))
		else $error("event enable not loaded");
	a_srq_en_load: assert property (
		(b.srq_en_wr && !b.rst) |=> srq_en == $past(b.wdata))
		else $error("service enable not loaded");
	a_srq_raise: assert property (
		(|(stb & srq_en & `CCS_MSS_MASK)) |=> srq) else $error("service request not raised");
endmodule

// ---- verilog/ccs_nvstore.sv ----
/*
 Protected user data bytes and setup save slots.
 Assumes the interpreter guards writes and commits lengths.
*/
`include "ccs_defs.svh"
module ccs_nvstore import ccs_pkg::*; #(
	parameter ccs_byte_t SETUP_DEF = 8'h00
)(
	// Clock and reset
	input  wire logic clock,
	input  wire logic reset_n,
	// Interpreter side
	ccs_if.store      b
);
	ccs_byte_t  mem [0:63], next_mem [0:63];
	ccs_byte_t  slots [0:3], next_slots [0:3];
	logic [6:0] len, next_len;

	// Next values of storage
	always_comb
	begin
		next_mem = mem;
		next_slots = slots;
		if (b.pud_wr)
			next_mem[b.pud_addr] = b.wdata;
		next_len = b.pud_commit ? b.pud_len_new : len;
		if (b.sav)
			next_slots[b.slot] = b.setup_in;
	end

	// Registers; user bytes hold over reset
	always_ff @(posedge clock)
	begin
		mem <= next_mem;
		if (!reset_n)
		begin
			len   <= `CCS_RST_LEN;
			slots <= '{default: SETUP_DEF};
		end
		else
		begin
			len   <= next_len;
			slots <= next_slots;
		end
	end

	assign b.pud_len   = len;
	assign b.pud_rdata = mem[b.pud_raddr];
	assign b.setup_out = slots[b.slot];

	default clocking cb @(posedge clock); endclocking
	default disable iff (!reset_n);

	a_pud_commit: assert property (
		b.pud_commit |=> len == $past(b.pud_len_new)) else $error("length not committed");
	a_sav_copy: assert property (
		b.sav |=> slots[$past(b.slot)] == $past(b.setup_in)) else $error("setup not saved");
endmodule

// ---- bench/ccs_ctrl_model.sv ----
/*
 Bus controller model: reads every reply byte, promptly or slowly.
 Assumes the reply port of the interpreter on the same clock.
*/
module ccs_ctrl_model (
	// Clock and reset
	input  wire logic       clock,
	input  wire logic       reset_n,
	// Reply port
	input  wire logic       reply_valid,
	input  wire logic [7:0] reply_byte,
	input  wire logic       reply_last,
	output logic            reply_ready,
	// Pacing
	input  wire logic       slow
);
	timeunit 1ns;
	timeprecision 1ns;
	logic [7:0] rx[$];
	logic       got_last = 1'b0;
	always @(negedge clock)
		reply_ready <= reset_n && (slow ? !reply_ready : 1'b1);
	// Collect taken bytes
	always @(posedge clock)
		if (reply_valid && reply_ready)
		begin
			rx.push_back(reply_byte);
			got_last <= reply_last;
		end
endmodule

// ---- bench/common_command_status_sync_bench.sv ----
/*
 Self-checking bench of the common command interpreter.
 Assumes the interpreter with default parameters and the model.
*/
module common_command_status_sync_bench import ccs_pkg::*;;
	timeunit 1ns;
	timeprecision 1ns;
	// ----------------------------------------
	// Signals
	// ----------------------------------------
	logic clock = 1'b0;
	logic reset_n, cmd_valid, cmd_ready, cmd_last, reply_valid, reply_last, reply_ready;
	logic ops_busy, nv_secure, tst_done, tst_fail, err_avail, tst_req, dev_trigger;
	logic trigger_stop, dev_reset, err_clear, setup_load, srq, slow;
	logic [4:0] cmd_code;
	logic [7:0] cmd_arg, reply_byte, evt_events, setup_value, seen;
	logic [15:0] state_change, isc_events;
	int failures = 0;
	int cmp_count = 0;
	// Clock
	always #20 clock = ~clock;
	// Sticky record of pulse outputs
	always @(posedge clock)
		seen <= seen | {2'b00, setup_load, err_clear, dev_reset, trigger_stop, tst_req,
			dev_trigger};
	ccs_interp uut (.clock, .reset_n, .cmd_valid, .cmd_ready, .cmd_code, .cmd_arg,
		.cmd_last, .reply_valid, .reply_byte, .reply_last, .reply_ready, .ops_busy,
		.nv_secure, .tst_done, .tst_fail, .err_avail, .evt_events,
		.isc_events, .hw_opts(8'h03), .sw_opts(8'h09), .setup_live(8'h5a),
		.tst_req, .dev_trigger, .trigger_stop, .dev_reset, .err_clear, .setup_load,
		.setup_value, .state_change, .srq);
	ccs_ctrl_model pc (.clock, .reset_n, .reply_valid, .reply_byte, .reply_last,
		.reply_ready, .slow);
	// ----------------------------------------
	// Shared tasks
	// ----------------------------------------
	task automatic chk(string what, logic [31:0] exp, logic [31:0] got);
		cmp_count++;
		if (got !== exp)
		begin
			failures++;
			$display("Error %s expected %0h seen %0h", what, exp, got);
		end
	endtask
	task automatic wt(int n);
		repeat (n) @(negedge clock);
	endtask
	// Offer one beat and hold it until taken
	task automatic send(logic [4:0] c, logic [7:0] a = 8'h00, logic l = 1'b0);
		cmd_valid = 1'b1;
		cmd_code = c;
		cmd_arg = a;
		cmd_last = l;
		for (int n = 0; n < 400 && cmd_ready !== 1'b1; n++)
			wt(1);
		chk("command ready", 1, cmd_ready);
		wt(1);
		cmd_valid = 1'b0;
		wt(1);
	endtask
	// Query and compare the whole reply
	task automatic query(logic [4:0] c, string exp);
		pc.rx.delete();
		pc.got_last = 1'b0;
		send(c);
		for (int n = 0; n < 400 && !pc.got_last; n++)
			wt(1);
		chk("reply end", 1, pc.got_last);
		chk("reply length", exp.len(), pc.rx.size());
		foreach (pc.rx[i])
			chk("reply byte", exp[i], pc.rx[i]);
	endtask
	task automatic summarize;
		$display("Comparisons %0d, mismatches %0d", cmp_count, failures);
		if (failures == 0 && cmp_count > 0)
			$display("Testbench passed");
		else
			$display("Testbench failed");
		$finish;
	endtask
	// ----------------------------------------
	// Scenarios
	// ----------------------------------------
	task automatic t_ident;
		chk("srq", 0, srq);
		chk("setup", 8'h00, setup_value);
		query(CMD_IDN_Q, "42,7,17");
		query(CMD_OPT_Q, "3,9");
		send(CMD_EVT_EN, 8'h21);
		send(CMD_SRQ_EN, 8'h20);
		query(CMD_EVT_EN_Q, "33");
		query(CMD_SRQ_EN_Q, "32");
		query(CMD_LRN_Q, "33,32,90");
	endtask
	task automatic t_opc;
		ops_busy = 1'b1;
		send(CMD_OPC);
		wt(4);
		chk("srq busy", 0, srq);
		ops_busy = 1'b0;
		wt(4);
		chk("srq done", 1, srq);
		slow = 1'b1;
		query(CMD_EVT_Q, "1");
		slow = 1'b0;
		query(CMD_EVT_Q, "0");
		err_avail = 1'b1;
		query(CMD_STB_Q, "4");
		err_avail = 1'b0;
	endtask
	task automatic t_sync;
		query(CMD_OPC_Q, "1");
		ops_busy = 1'b1;
		fork
			query(CMD_OPC_Q, "1");
			begin
				wt(10);
				chk("early reply", 0, pc.rx.size());
				ops_busy = 1'b0;
			end
		join
		ops_busy = 1'b1;
		seen = 8'h00;
		send(CMD_WAI);
		fork
			send(CMD_TRG);
			begin
				wt(6);
				chk("trigger held", 0, seen[0]);
				ops_busy = 1'b0;
			end
		join
		chk("trigger", 1, seen[0]);
	endtask
	task automatic t_cls;
		ops_busy = 1'b1;
		send(CMD_OPC);
		evt_events = 8'h20;
		isc_events = 16'h0003;
		wt(1);
		evt_events = 8'h00;
		isc_events = 16'h0000;
		chk("state change", 16'h0003, state_change);
		query(CMD_STB_Q, "97");
		chk("srq enabled", 1, srq);
		seen = 8'h00;
		send(CMD_CLS);
		ops_busy = 1'b0;
		wt(3);
		chk("error clear", 1, seen[4]);
		chk("state cleared", 16'h0000, state_change);
		query(CMD_EVT_Q, "0");
	endtask
	task automatic t_pud;
		nv_secure = 1'b1;
		send(CMD_PUD, 8'h41, 1'b1);
		nv_secure = 1'b0;
		query(CMD_EVT_Q, "16");
		send(5'h1f);
		query(CMD_EVT_Q, "32");
		send(CMD_PUD, 8'h41);
		send(CMD_PUD, 8'h42, 1'b1);
		query(CMD_PUD_Q, "AB");
		for (int i = 0; i < 65; i++)
			send(CMD_PUD, 8'h43, i == 64);
		query(CMD_EVT_Q, "16");
		query(CMD_PUD_Q, "CC");
	endtask
	task automatic t_setup;
		send(CMD_SAV, 8'h01);
		seen = 8'h00;
		send(CMD_RST);
		chk("stop and reset", 2'b11, seen[3:2]);
		chk("setup reset", 8'h00, setup_value);
		query(CMD_EVT_EN_Q, "0");
		seen = 8'h00;
		send(CMD_RCL, 8'h01);
		chk("setup load", 1, seen[5]);
		chk("setup value", 8'h5a, setup_value);
		seen = 8'h00;
		fork
			query(CMD_TST_Q, "1");
			begin
				wt(5);
				chk("test request", 1, seen[1]);
				tst_fail = 1'b1;
				tst_done = 1'b1;
				wt(1);
				tst_done = 1'b0;
			end
		join
	endtask
	// ----------------------------------------
	// Main sequence and watchdog
	// ----------------------------------------
	initial
	begin
		{reset_n, cmd_valid, cmd_code, cmd_arg, cmd_last, seen} = '0;
		{ops_busy, nv_secure, tst_done, tst_fail, err_avail, evt_events, slow} = '0;
		isc_events = 16'h0000;
		wt(2);
		reset_n = 1'b1;
		t_ident;
		t_opc;
		t_sync;
		t_cls;
		t_pud;
		t_setup;
		summarize;
	end
	initial
	begin
		#(40 * 5000);
		failures++;
		summarize;
	end
endmodule
